// [pol_pkg.sv]
// Constants and types shared by the positioning option logic
`default_nettype none
package pol_pkg;
	// ---------------------------------------------------------------
	// Object dictionary map
	// ---------------------------------------------------------------
	localparam logic [15:0] POL_IDX_FEED_REVS   = 16'h60ee;
	localparam logic [15:0] POL_IDX_OPTION      = 16'h60f2;
	localparam logic [7:0]  POL_SUB_COUNT       = 8'h00;
	localparam logic [7:0]  POL_SUB_FIRST_FB    = 8'h01;
	localparam logic [7:0]  POL_FEEDBACK_COUNT  = 8'h03;
	localparam logic [31:0] POL_REVS_RESET      = 32'h0000_0001;
	localparam logic [15:0] POL_OPTION_RESET    = 16'h0001;

	// ---------------------------------------------------------------
	// Option word field positions
	// ---------------------------------------------------------------
	localparam int POL_REL_LSB = 0;
	localparam int POL_HS_LSB  = 4;
	localparam int POL_ROT_LSB = 6;

	// ---------------------------------------------------------------
	// Field codes
	// ---------------------------------------------------------------
	typedef enum logic [1:0] {
		REL_PREV_TARGET = 2'h0,
		REL_RAMP        = 2'h1,
		REL_ACTUAL      = 2'h2,
		REL_RESERVED    = 2'h3
	} pol_rel_t;

	typedef enum logic [1:0] {
		HSR_NORMAL   = 2'h0,
		HSR_ON_REACH = 2'h1,
		HSR_AT_ONCE  = 2'h2,
		HSR_RESERVED = 2'h3
	} pol_hsr_t;

	typedef enum logic [1:0] {
		ROT_LINEAR   = 2'h0,
		ROT_NEGATIVE = 2'h1,
		ROT_POSITIVE = 2'h2,
		ROT_SHORTEST = 2'h3
	} pol_rot_t;

	// Handshake states, Gray order along idle -> ack -> released
	typedef enum logic [1:0] {
		HS_IDLE = 2'h0,
		HS_ACK  = 2'h1,
		HS_REL  = 2'h3
	} pol_hs_t;

	// ---------------------------------------------------------------
	// Carriers
	// ---------------------------------------------------------------
	typedef struct packed {
		logic        wr;
		logic        rd;
		logic [15:0] index;
		logic [7:0]  sub;
		logic [31:0] wdata;
	} pol_od_req_t;

	typedef struct packed {
		logic signed [31:0] min_pos;
		logic signed [31:0] max_pos;
	} pol_limits_t;
endpackage
`default_nettype wire

// [pol_div.sv]
// Free-running iterative unsigned divider, one quotient per W+1 cycles
`default_nettype none
module pol_div import pol_pkg::*; #(
	parameter int W = 32
) (
	input  wire logic         clk_i,      // Drive clock
	input  wire logic         reset_i,    // Async reset, high
	input  wire logic [W-1:0] dividend_i, // Feed value
	input  wire logic [W-1:0] divisor_i,  // Shaft revolutions
	output logic      [W-1:0] quot_o      // Last finished quotient
);
	localparam int CW = $clog2(W + 1);

	initial begin
		if (W < 2)
			$error("pol_div: W must be at least 2");
	end

	logic [W-1:0]  num_r;
	logic [W-1:0]  den_r;
	logic [W-1:0]  q_r;
	logic [W:0]    rem_r;
	logic [CW-1:0] cnt_r;
	logic [W:0]    trial;

	assign trial = {rem_r[W-1:0], num_r[W-1]} - {1'b0, den_r};

	// ---------------------------------------------------------------
	// Shift-subtract loop, restarts with fresh operands
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			num_r  <= '0;
			den_r  <= '0;
			q_r    <= '0;
			rem_r  <= '0;
			cnt_r  <= '0;
			quot_o <= '0;
		end else if (cnt_r == '0) begin
			num_r <= dividend_i;
			den_r <= divisor_i;
			q_r   <= '0;
			rem_r <= '0;
			cnt_r <= CW'(W);
		end else begin
			num_r <= {num_r[W-2:0], 1'b0};
			if (!trial[W]) begin
				rem_r <= trial;
				q_r   <= {q_r[W-2:0], 1'b1};
			end else begin
				rem_r <= {rem_r[W-1:0], num_r[W-1]};
				q_r   <= {q_r[W-2:0], 1'b0};
			end
			if (cnt_r == CW'(1))
				quot_o <= trial[W] ? {q_r[W-2:0], 1'b0}
				                   : {q_r[W-2:0], 1'b1};
			cnt_r <= cnt_r - CW'(1);
		end
	end
endmodule
`default_nettype wire

// [pol_logic.sv]
// Positioning option decode and feed-constant storage
`default_nettype none
// Behaviour
// - Read-only entry reports feedback count, three
// - One writable revolution count per feedback
// - Feed constant is feed over revolutions
// - Sixteen-bit option word, preset one, fields
// - Relative code 00 offsets from previous target
// - Relative code 01 offsets from ramp output
// - Relative code 10 offsets from actual position
// - Device acknowledges, then clears setpoint bit
// - Code 00 keeps master-driven setpoint handshake
// - Code 01 releases bit on target reached
// - Code 10 releases bit at once
// - Linear mode wraps demand at range limits
// - Moves beyond modulo range only linear
// - Code 01 always moves negative
// - Code 10 always moves positive
// - Code 11 takes shortest path
module pol_logic import pol_pkg::*; #(
	parameter int NUM_FB = int'(POL_FEEDBACK_COUNT)
) (
	input  wire logic               clk_i,            // Drive clock
	input  wire logic               reset_i,          // Async reset, high
	input  wire pol_od_req_t        od_req_i,         // Dictionary access
	output logic [31:0]             od_rdata_o,       // Read data
	output logic                    od_ack_o,         // Access done pulse
	output logic                    od_err_o,         // Access refused
	input  wire logic               cw_new_sp_i,      // Controlword bit 4
	input  wire logic               cw_relative_i,    // Controlword bit 6
	input  wire logic signed [31:0] setpoint_i,       // Commanded target
	input  wire logic signed [31:0] ramp_pos_i,       // Ramp output
	input  wire logic signed [31:0] actual_pos_i,     // Measured position
	input  wire logic               target_reached_i, // Move finished
	input  wire pol_limits_t        limits_i,         // Range limits
	input  wire logic signed [31:0] demand_i,         // Raw demand
	input  wire logic [NUM_FB-1:0][31:0] feed_i,      // Feed per feedback
	output logic signed [31:0]      target_o,         // Absolute target
	output logic                    target_valid_o,   // New target pulse
	output logic                    dir_pos_o,        // Move positive
	output logic                    long_move_ok_o,   // Multi-turn allowed
	output logic signed [31:0]      demand_o,         // Wrapped demand
	output logic                    sp_ack_o,         // Statusword bit 12
	output logic                    clear_new_sp_o,   // Clear bit 4 pulse
	output logic [NUM_FB-1:0][31:0] feed_const_o      // Feed constants
);
	initial begin
		if (NUM_FB < 1 || NUM_FB > 254)
			$error("pol_logic: NUM_FB must be 1 to 254");
	end

	// ---------------------------------------------------------------
	// Stored entries
	// ---------------------------------------------------------------
	logic [NUM_FB-1:0][31:0] revs_r;
	logic [15:0]             option_r;
	pol_rel_t                rel_sel;
	pol_hsr_t                hsr_sel;
	pol_rot_t                rot_sel;
	logic [7:0]              fb_sel;
	logic                    sub_is_fb;

	assign fb_sel    = od_req_i.sub - POL_SUB_FIRST_FB;
	assign sub_is_fb = (od_req_i.sub >= POL_SUB_FIRST_FB) &&
	                   (od_req_i.sub <= 8'(NUM_FB));

	assign rel_sel = pol_rel_t'(option_r[POL_REL_LSB +: 2]);
	assign hsr_sel = pol_hsr_t'(option_r[POL_HS_LSB +: 2]);
	assign rot_sel = pol_rot_t'(option_r[POL_ROT_LSB +: 2]);

	// ---------------------------------------------------------------
	// Dictionary writes
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			for (int i = 0; i < NUM_FB; i++)
				revs_r[i] <= POL_REVS_RESET;
			option_r <= POL_OPTION_RESET;
		end else if (od_req_i.wr) begin
			if (od_req_i.index == POL_IDX_FEED_REVS && sub_is_fb)
				revs_r[fb_sel] <= od_req_i.wdata;
			if (od_req_i.index == POL_IDX_OPTION &&
			    od_req_i.sub == POL_SUB_COUNT)
				option_r <= od_req_i.wdata[15:0];
		end
	end

	// ---------------------------------------------------------------
	// Dictionary answers, one cycle after the request
	// ---------------------------------------------------------------
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			od_rdata_o <= '0;
			od_ack_o   <= 1'b0;
			od_err_o   <= 1'b0;
		end else begin
			od_ack_o <= od_req_i.wr | od_req_i.rd;
			od_err_o <= 1'b0;
			if (od_req_i.wr | od_req_i.rd) begin
				od_rdata_o <= '0;
				if (od_req_i.index == POL_IDX_FEED_REVS &&
				    od_req_i.sub == POL_SUB_COUNT) begin
					od_rdata_o <= {24'h000000, 8'(NUM_FB)};
					od_err_o   <= od_req_i.wr;
				end else if (od_req_i.index == POL_IDX_FEED_REVS &&
				             sub_is_fb) begin
					od_rdata_o <= revs_r[fb_sel];
				end else if (od_req_i.index == POL_IDX_OPTION &&
				             od_req_i.sub == POL_SUB_COUNT) begin
					od_rdata_o <= {16'h0000, option_r};
				end else begin
					od_err_o <= 1'b1;
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Feed constants
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < NUM_FB; g++) begin : g_fb
			pol_div #(
				.W(32)
			) u_div (
				.clk_i      (clk_i),
				.reset_i    (reset_i),
				.dividend_i (feed_i[g]),
				.divisor_i  (revs_r[g]),
				.quot_o     (feed_const_o[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// Setpoint handshake
	// ---------------------------------------------------------------
	pol_hs_t hs_r;
	logic    nsp_q_r;
	logic    accept;

	assign accept = (hs_r == HS_IDLE) && cw_new_sp_i && !nsp_q_r;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i)
			nsp_q_r <= 1'b0;
		else
			nsp_q_r <= cw_new_sp_i;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			hs_r           <= HS_IDLE;
			sp_ack_o       <= 1'b0;
			clear_new_sp_o <= 1'b0;
		end else begin
			clear_new_sp_o <= 1'b0;
			case (hs_r)
				HS_IDLE: begin
					if (accept) begin
						sp_ack_o <= 1'b1;
						hs_r     <= HS_ACK;
					end
				end
				HS_ACK: begin
					case (hsr_sel)
						HSR_ON_REACH: begin
							if (!cw_new_sp_i) begin
								sp_ack_o <= 1'b0;
								hs_r     <= HS_IDLE;
							end else if (target_reached_i &&
							             !target_valid_o) begin
								clear_new_sp_o <= 1'b1;
								hs_r           <= HS_REL;
							end
						end
						HSR_AT_ONCE: begin
							clear_new_sp_o <= 1'b1;
							hs_r           <= HS_REL;
						end
						default: begin
							if (!cw_new_sp_i) begin
								sp_ack_o <= 1'b0;
								hs_r     <= HS_IDLE;
							end
						end
					endcase
				end
				HS_REL: begin
					sp_ack_o <= 1'b0;
					if (!cw_new_sp_i && !clear_new_sp_o)
						hs_r <= HS_IDLE;
				end
				default: begin
					sp_ack_o <= 1'b0;
					hs_r     <= HS_IDLE;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Target calculation
	// ---------------------------------------------------------------
	logic signed [31:0] prev_target_r;
	logic signed [31:0] raw_target_r;
	logic               pend_r;
	logic signed [31:0] base;
	logic signed [31:0] folded;
	logic               dir_pos;

	always_comb begin
		base = prev_target_r;
		case (rel_sel)
			REL_RAMP:   base = ramp_pos_i;
			REL_ACTUAL: base = actual_pos_i;
			default:    base = prev_target_r;
		endcase
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			raw_target_r <= '0;
			pend_r       <= 1'b0;
		end else begin
			pend_r <= accept;
			if (accept) begin
				if (cw_relative_i)
					raw_target_r <= base + setpoint_i;
				else
					raw_target_r <= setpoint_i;
			end
		end
	end

	pol_path u_path (
		.rot_sel_i  (rot_sel),
		.target_i   (raw_target_r),
		.actual_i   (actual_pos_i),
		.limits_i   (limits_i),
		.target_o   (folded),
		.dir_pos_o  (dir_pos)
	);

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			prev_target_r  <= '0;
			target_o       <= '0;
			target_valid_o <= 1'b0;
			dir_pos_o      <= 1'b1;
		end else begin
			target_valid_o <= pend_r;
			if (pend_r) begin
				prev_target_r <= folded;
				target_o      <= folded;
				dir_pos_o     <= dir_pos;
			end
		end
	end

	// ---------------------------------------------------------------
	// Demand wrap and multi-turn permission
	// ---------------------------------------------------------------
	logic signed [31:0] span;

	assign span = limits_i.max_pos - limits_i.min_pos;

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			demand_o       <= '0;
			long_move_ok_o <= 1'b1;
		end else begin
			long_move_ok_o <= (rot_sel == ROT_LINEAR);
			demand_o       <= demand_i;
			if (rot_sel == ROT_LINEAR) begin
				if (demand_i >= limits_i.max_pos)
					demand_o <= demand_i - span;
				else if (demand_i < limits_i.min_pos)
					demand_o <= demand_i + span;
			end
		end
	end
endmodule
`default_nettype wire

// [pol_path.sv]
// Rotary target folding and direction choice
`default_nettype none
module pol_path import pol_pkg::*; (
	input  wire pol_rot_t           rot_sel_i, // Direction code
	input  wire logic signed [31:0] target_i,  // Raw target
	input  wire logic signed [31:0] actual_i,  // Actual position
	input  wire pol_limits_t        limits_i,  // Range limits
	output logic signed [31:0]      target_o,  // Folded target
	output logic                    dir_pos_o  // Move positive
);
	logic signed [31:0] span;
	logic signed [31:0] fwd;

	assign span = limits_i.max_pos - limits_i.min_pos;

	always_comb begin
		target_o = target_i;
		// fold into one turn unless linear
		if (rot_sel_i != ROT_LINEAR) begin
			if (target_i > limits_i.max_pos)
				target_o = target_i - span;
			else if (target_i < limits_i.min_pos)
				target_o = target_i + span;
		end
		fwd = target_o - actual_i;
		if (fwd < 0)
			fwd = fwd + span;
		case (rot_sel_i)
			ROT_NEGATIVE: dir_pos_o = 1'b0;
			ROT_POSITIVE: dir_pos_o = 1'b1;
			ROT_SHORTEST: dir_pos_o = fwd < (span >>> 1);
			default:      dir_pos_o = target_o >= actual_i;
		endcase
	end
endmodule
`default_nettype wire

// [pol_logic_checker.sv]
// Port assertions for the positioning option logic
`default_nettype none
module pol_logic_checker import pol_pkg::*; (
	input wire logic               clk_i,            // Drive clock
	input wire logic               reset_i,          // Async reset
	input wire pol_od_req_t        od_req_i,         // Dictionary access
	input wire logic               od_ack_o,         // Access done
	input wire logic               od_err_o,         // Access refused
	input wire logic               cw_new_sp_i,      // New setpoint bit
	input wire logic               target_reached_i, // Move finished
	input wire pol_limits_t        limits_i,         // Range limits
	input wire logic signed [31:0] demand_i,         // Raw demand
	input wire logic               target_valid_o,   // New target
	input wire logic               long_move_ok_o,   // Linear mode
	input wire logic signed [31:0] demand_o,         // Wrapped demand
	input wire logic               sp_ack_o,         // Setpoint ack
	input wire logic               clear_new_sp_o    // Clear request
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (reset_i);
	logic               rq;
	logic signed [31:0] span;
	assign rq = od_req_i.wr | od_req_i.rd;
	assign span = limits_i.max_pos - limits_i.min_pos;

	chk_ack_next: assert property (rq |=> od_ack_o)
		else $error("access not answered next cycle");
	chk_count_ro: assert property (od_req_i.wr
		&& od_req_i.index == POL_IDX_FEED_REVS
		&& od_req_i.sub == POL_SUB_COUNT |=> od_err_o)
		else $error("count write not refused");
	chk_ack_cause: assert property ($rose(sp_ack_o) |->
		$past(cw_new_sp_i) && !$past(cw_new_sp_i, 2))
		else $error("ack without setpoint edge");
	chk_valid_after: assert property ($rose(sp_ack_o)
		|=> target_valid_o)
		else $error("target not issued after ack");
	chk_clear_ack: assert property (clear_new_sp_o
		|-> sp_ack_o ##1 !sp_ack_o)
		else $error("ack not dropped after clear");
	chk_clear_cause: assert property (clear_new_sp_o
		|-> target_valid_o || $past(target_reached_i))
		else $error("clear without cause");
	chk_demand_wrap: assert property (long_move_ok_o
		&& $past(demand_i) >= $past(limits_i.max_pos)
		|-> demand_o == $past(demand_i) - $past(span))
		else $error("demand not wrapped at max");
	chk_demand_pass: assert property (!long_move_ok_o
		|-> demand_o == $past(demand_i))
		else $error("demand altered in rotary mode");

	cov_clear_now: cover property (clear_new_sp_o && target_valid_o);
	cov_refused: cover property (od_err_o);
	cov_rotary: cover property (!long_move_ok_o && target_valid_o);
endmodule

bind pol_logic pol_logic_checker chk (.clk_i, .reset_i, .od_req_i,
	.od_ack_o, .od_err_o, .cw_new_sp_i, .target_reached_i, .limits_i,
	.demand_i, .target_valid_o, .long_move_ok_o, .demand_o, .sp_ack_o,
	.clear_new_sp_o);
`default_nettype wire

// [pol_master.sv]
// Fieldbus master model that reads and writes dictionary entries
`default_nettype none
module pol_master import pol_pkg::*; (
	input  wire logic        clk_i,   // Drive clock
	output var pol_od_req_t  req_o,   // Dictionary access
	input  wire logic [31:0] rdata_i, // Read data
	input  wire logic        ack_i,   // Access done
	input  wire logic        err_i    // Access refused
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [31:0] rd_q;
	logic        ok_q;
	logic        err_q;
	initial req_o = '0;
	// ---------------------------------------------------------------
	// One-cycle request, answer taken one edge later
	// ---------------------------------------------------------------
	task automatic access(input logic w, input logic [15:0] i,
		input logic [7:0] s, input logic [31:0] d);
		req_o <= '{w, ~w, i, s, d};
		@(posedge clk_i);
		// Released fields stop showing the last value
		req_o <= '{1'h0, 1'h0, ~i, ~s, ~d};
		@(posedge clk_i);
		ok_q = ack_i;
		err_q = err_i;
		rd_q = rdata_i;
	endtask
endmodule
`default_nettype wire

// [pol_logic_tb_top.sv]
// Self-checking bench for the positioning option logic
`default_nettype none
module pol_logic_tb_top import pol_pkg::*; ;
	timeunit 1ns;
	timeprecision 1ps;
	logic               clk_i, reset_i, nsp, rel, reached;
	logic               ack, err, valid, dirp, lmo, spack, clr;
	logic signed [31:0] sp, ramp, act, dem, tgt, dem_o;
	logic        [31:0] rdata;
	pol_od_req_t        req;
	pol_limits_t        lim;
	logic [2:0][31:0]   feed, fc;
	int                 fail_count, tests_run;

	pol_logic #(.NUM_FB(3)) dut (.clk_i, .reset_i, .od_req_i(req),
		.od_rdata_o(rdata), .od_ack_o(ack), .od_err_o(err),
		.cw_new_sp_i(nsp), .cw_relative_i(rel), .setpoint_i(sp),
		.ramp_pos_i(ramp), .actual_pos_i(act), .target_reached_i(reached),
		.limits_i(lim), .demand_i(dem), .feed_i(feed), .target_o(tgt),
		.target_valid_o(valid), .dir_pos_o(dirp), .long_move_ok_o(lmo),
		.demand_o(dem_o), .sp_ack_o(spack), .clear_new_sp_o(clr),
		.feed_const_o(fc));
	pol_master m (.clk_i, .req_o(req), .rdata_i(rdata), .ack_i(ack),
		.err_i(err));

	initial begin
		clk_i = 1'h0;
		forever #10 clk_i = ~clk_i;
	end
	// ---------------------------------------------------------------
	// Shared checks and bus cycles
	// ---------------------------------------------------------------
	task automatic chk(input logic [31:0] g, x);
		tests_run++;
		if (g !== x) begin
			fail_count++;
			$display("mismatch at %0t: got %h want %h", $time, g, x);
		end
	endtask
	task automatic od(input logic w, input logic [15:0] i,
		input logic [7:0] s, input logic [31:0] d, e, input logic ee);
		m.access(w, i, s, d);
		chk(m.ok_q, 1'h1);
		chk(m.err_q, ee);
		if (!w)
			chk(m.rd_q, e);
	endtask
	task automatic wait_hi(ref logic s);
		int n;
		n = 0;
		do begin
			@(posedge clk_i);
			n++;
		end while (s !== 1'h1 && n < 8);
	endtask
	task automatic move(input logic [15:0] o, input logic r,
		input logic [31:0] s, e, input logic d);
		od(1'h1, POL_IDX_OPTION, 8'h0, {16'h0, o}, 32'h0, 1'h0);
		rel <= r;
		sp <= s;
		nsp <= 1'h1;
		wait_hi(valid);
		chk(valid, 1'h1);
		chk(tgt, e);
		chk(dirp, d);
		chk(clr, o[5:4] == 2'h2);
		if (o[5:4] == 2'h1) begin
			reached <= 1'h1;
			wait_hi(clr);
			reached <= 1'h0;
			chk(clr, 1'h1);
		end
		if (o[5:4] == 2'h1 || o[5:4] == 2'h2) begin
			@(posedge clk_i);
			chk(spack, 1'h0);
		end else begin
			repeat (3) @(posedge clk_i);
			chk(spack, 1'h1);
		end
		nsp <= 1'h0;
		repeat (3) @(posedge clk_i);
		chk(spack, 1'h0);
	endtask
	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_regs();
		od(1'h0, POL_IDX_FEED_REVS, 8'h0, 32'h0, 32'h3, 1'h0);
		od(1'h1, POL_IDX_FEED_REVS, 8'h0, 32'h7, 32'h0, 1'h1);
		od(1'h0, POL_IDX_FEED_REVS, 8'h0, 32'h0, 32'h3, 1'h0);
		od(1'h0, POL_IDX_FEED_REVS, 8'h1, 32'h0, 32'h1, 1'h0);
		od(1'h1, POL_IDX_FEED_REVS, 8'h2, 32'h4, 32'h0, 1'h0);
		od(1'h1, POL_IDX_FEED_REVS, 8'h3, 32'h3, 32'h0, 1'h0);
		od(1'h0, POL_IDX_FEED_REVS, 8'h2, 32'h0, 32'h4, 1'h0);
		od(1'h0, POL_IDX_FEED_REVS, 8'h4, 32'h0, 32'h0, 1'h1);
		od(1'h0, POL_IDX_OPTION, 8'h0, 32'h0, 32'h1, 1'h0);
		od(1'h1, POL_IDX_OPTION, 8'h0, 32'hffff_ff0f, 32'h0, 1'h0);
		od(1'h0, POL_IDX_OPTION, 8'h0, 32'h0, 32'hff0f, 1'h0);
		od(1'h0, 16'h60f4, 8'h0, 32'h0, 32'h0, 1'h1);
		$display("test regs done");
	endtask
	task automatic t_feed();
		repeat (70) @(posedge clk_i);
		chk(fc[0], 32'h12c);
		chk(fc[1], 32'ha);
		chk(fc[2], 32'h21);
		$display("test feed done");
	endtask
	task automatic t_rel();
		logic [31:0] ex[4] = '{32'h69, 32'h3ed, 32'h7d5, 32'h7da};
		move(16'h0020, 1'h0, 32'h64, 32'h64, 1'h0);
		for (int i = 0; i < 4; i++)
			move({8'h0, 2'h0, i[1:0], 2'h0, i[1:0]}, 1'h1, 32'h5,
				ex[i], ex[i] >= 32'h7d0);
		$display("test relative done");
	endtask
	task automatic t_rot();
		logic [1:0]  rc[5] = '{2'h0, 2'h1, 2'h2, 2'h3, 2'h3};
		logic [31:0] tv[5] = '{32'hbb8, 32'hbb8, 32'h64, 32'h9c4, 32'h64};
		logic        dv[5] = '{1'h1, 1'h0, 1'h1, 1'h1, 1'h0};
		for (int i = 0; i < 5; i++) begin
			move({8'h0, rc[i], 6'h20}, 1'h0, tv[i], tv[i], dv[i]);
			chk(lmo, rc[i] == 2'h0);
		end
		dem <= 32'hfa0;
		repeat (2) @(posedge clk_i);
		chk(dem_o, 32'hfa0);
		od(1'h1, POL_IDX_OPTION, 8'h0, 32'h0, 32'h0, 1'h0);
		repeat (2) @(posedge clk_i);
		chk(dem_o, 32'h0);
		dem <= 32'hffff_ffff;
		repeat (2) @(posedge clk_i);
		chk(dem_o, 32'hf9f);
		$display("test rotary done");
	endtask
	task automatic conclude();
		$display("comparisons %0d mismatches %0d", tests_run, fail_count);
		if (fail_count == 0 && tests_run > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask

	initial begin
		fail_count = 0;
		tests_run = 0;
		reset_i = 1'h1;
		{nsp, rel, reached} = 3'h0;
		sp = 32'h0;
		ramp = 32'h3e8;
		act = 32'h7d0;
		dem = 32'h0;
		lim = '{32'h0, 32'hfa0};
		feed = '{32'h63, 32'h28, 32'h12c};
		repeat (2) @(posedge clk_i);
		reset_i <= 1'h0;
		@(posedge clk_i);
		t_regs();
		t_feed();
		t_rel();
		t_rot();
		conclude();
	end
	initial begin
		repeat (10000) @(posedge clk_i);
		fail_count++;
		conclude();
	end
endmodule
`default_nettype wire
